// *** hdl/hac_trigger_control.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// - One enable bit aliased at two locations
// - Measure every selected input once per trigger
// - Selects reset to zero; software sets first
// - Select bits map to fixed input channels
// - Bit 14 picks polling or continuous mode
// - One-shot bit starts set, clears when done
// - Continuous mode starts sets periodically
// - Rate field sets period, 1Hz to 256Hz
// - Gate pin may block or start sets
// - Gate mode field decodes ignore, block, start
// - Gate start mode overrides other scheduling
// - Gate polarity taken from GPIO configuration
// - Gate edge starts one set
module hac_trigger_control
#(
  parameter int P_TICK_CYCLES = hac_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  // Register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output var  logic [15:0] o_reg_rdata,
  // Gate input
  input  wire logic        i_gate_pin,
  input  wire logic        i_gpio_polarity_config,
  // Converter
  output var  logic        o_converter_enable,
  output var  logic        o_conv_start,
  output var  logic [2:0]  o_conv_channel,
  input  wire logic        i_conv_done,
  // Status
  output var  logic        o_busy
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  hac_pkg::hac_state_t state_reg;
  hac_pkg::hac_state_t state_next;

  logic       enable_reg;
  logic       enable_next;
  logic       cont_reg;
  logic       cont_next;
  logic       one_shot_reg;
  logic [7:0] select_reg;
  logic [1:0] gate_mode_reg;
  logic [2:0] rate_reg;
  logic [7:0] pending_reg;
  logic       gate_s1_reg;
  logic       gate_s2_reg;
  logic       gate_s3_reg;

  logic       wr_pwr;
  logic       wr_ctrl;
  logic       wr_ctrl2;
  logic       poll_write_one;
  logic       gate_start_mode;
  logic       gate_asserted;
  logic       gate_edge;
  logic       blocked;
  logic       period_pulse;
  logic       trig;
  logic       set_begin;
  logic       last_done;
  logic       set_done;
  logic [7:0] pending_left;

  function automatic logic [2:0] first_set(input logic [7:0] mask);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (mask[i])
        idx = 3'(i);
    first_set = idx;
  endfunction

  // ****************************************************************
  // Register writes
  // ****************************************************************
  assign wr_pwr   = i_reg_wr && (i_reg_addr == hac_pkg::ADDR_PWR_MGMT5);
  assign wr_ctrl  = i_reg_wr && (i_reg_addr == hac_pkg::ADDR_TRIG_CTRL);
  assign wr_ctrl2 = i_reg_wr && (i_reg_addr == hac_pkg::ADDR_TRIG_CTRL2);

  always_comb
  begin
    enable_next = enable_reg;
    if (wr_pwr)
      enable_next = i_reg_wdata[hac_pkg::ENABLE_PWR_BIT];
    else if (wr_ctrl)
      enable_next = i_reg_wdata[hac_pkg::ENABLE_CTRL_BIT];
  end

  assign cont_next = wr_ctrl ? i_reg_wdata[hac_pkg::CONT_BIT] : cont_reg;

  // A one-shot request only sticks where polling is the live source
  assign poll_write_one = wr_ctrl && i_reg_wdata[hac_pkg::POLL_BIT] && enable_next
                          && !cont_next && !gate_start_mode;

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      enable_reg <= hac_pkg::ENABLE_RST;
      cont_reg   <= hac_pkg::CONT_RST;
      select_reg <= hac_pkg::SEL_RST;
    end
    else
    begin
      enable_reg <= enable_next;
      cont_reg   <= cont_next;
      if (wr_ctrl)
        select_reg <= i_reg_wdata[hac_pkg::SEL_MSB:hac_pkg::SEL_LSB];
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      gate_mode_reg <= hac_pkg::GATE_MODE_RST;
      rate_reg      <= hac_pkg::RATE_RST;
    end
    else if (wr_ctrl2)
    begin
      gate_mode_reg <= i_reg_wdata[hac_pkg::GATE_MODE_MSB:hac_pkg::GATE_MODE_LSB];
      rate_reg      <= i_reg_wdata[hac_pkg::RATE_MSB:hac_pkg::RATE_LSB];
    end
  end

  // Set wins over the self-clear so a back-to-back request is kept
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      one_shot_reg <= hac_pkg::POLL_RST;
    else if (!enable_next)
      one_shot_reg <= 1'h0;
    else if (poll_write_one)
      one_shot_reg <= 1'h1;
    else if (set_done)
      one_shot_reg <= 1'h0;
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      o_reg_rdata <= 16'h0000;
    else if (i_reg_rd)
    begin
      o_reg_rdata <= 16'h0000;
      case (i_reg_addr)
        hac_pkg::ADDR_PWR_MGMT5:
          o_reg_rdata[hac_pkg::ENABLE_PWR_BIT] <= enable_reg;
        hac_pkg::ADDR_TRIG_CTRL:
        begin
          o_reg_rdata[hac_pkg::ENABLE_CTRL_BIT] <= enable_reg;
          o_reg_rdata[hac_pkg::CONT_BIT]        <= cont_reg;
          o_reg_rdata[hac_pkg::POLL_BIT]        <= one_shot_reg;
          o_reg_rdata[hac_pkg::SEL_MSB:hac_pkg::SEL_LSB] <= select_reg;
        end
        hac_pkg::ADDR_TRIG_CTRL2:
        begin
          o_reg_rdata[hac_pkg::GATE_MODE_MSB:hac_pkg::GATE_MODE_LSB] <= gate_mode_reg;
          o_reg_rdata[hac_pkg::RATE_MSB:hac_pkg::RATE_LSB]           <= rate_reg;
        end
        default:
          o_reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // Gate input
  // ****************************************************************
  // Pin is asynchronous; third stage feeds the edge detector only
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      gate_s1_reg <= 1'h0;
      gate_s2_reg <= 1'h0;
      gate_s3_reg <= 1'h0;
    end
    else
    begin
      gate_s1_reg <= i_gate_pin;
      gate_s2_reg <= gate_s1_reg;
      gate_s3_reg <= gate_s2_reg;
    end
  end

  assign gate_asserted   = gate_s2_reg == i_gpio_polarity_config;
  assign gate_edge       = (gate_s2_reg != gate_s3_reg) && gate_asserted;
  assign gate_start_mode = gate_mode_reg == hac_pkg::GATE_START;
  // Reserved gate mode behaves like ignore
  assign blocked         = (gate_mode_reg == hac_pkg::GATE_BLOCK) && gate_asserted;

  // ****************************************************************
  // Trigger selection
  // ****************************************************************
  hac_rate_divider
  #(
    .P_TICK_CYCLES (P_TICK_CYCLES)
  )
  u_rate_divider
  (
    .i_mclk   (i_mclk),
    .i_reset  (i_reset),
    .i_run    (enable_reg && cont_reg && !gate_start_mode),
    .i_rate   (rate_reg),
    .o_period (period_pulse)
  );

  always_comb
  begin
    if (gate_start_mode)
      trig = gate_edge;
    else if (blocked)
      trig = 1'h0;
    else if (cont_reg)
      trig = period_pulse;
    else
      trig = one_shot_reg;
  end

  // Only an idle sequencer listens, so late triggers are dropped
  assign set_begin    = (state_reg == hac_pkg::ST_IDLE) && enable_reg && trig;
  assign pending_left = pending_reg & ~(8'h01 << o_conv_channel);
  assign last_done    = (state_reg == hac_pkg::ST_WAIT) && i_conv_done
                        && (pending_left == 8'h00);
  assign set_done     = last_done || (set_begin && (select_reg == 8'h00));

  // ****************************************************************
  // Measurement sequencer
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      hac_pkg::ST_IDLE:
        if (set_begin && (select_reg != 8'h00))
          state_next = hac_pkg::ST_START;
      hac_pkg::ST_START:
        state_next = hac_pkg::ST_WAIT;
      hac_pkg::ST_WAIT:
        if (i_conv_done)
          state_next = (pending_left == 8'h00) ? hac_pkg::ST_IDLE : hac_pkg::ST_START;
      default:
        state_next = hac_pkg::ST_IDLE;
    endcase
    if (!enable_reg)
      state_next = hac_pkg::ST_IDLE;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      state_reg <= hac_pkg::ST_IDLE;
      o_busy    <= 1'h0;
    end
    else
    begin
      state_reg <= state_next;
      o_busy    <= state_next != hac_pkg::ST_IDLE;
    end
  end

  // Selects are latched per set so a mid-set write cannot tear it
  always_ff @(posedge i_mclk)
  begin
    if (i_reset || !enable_reg)
      pending_reg <= 8'h00;
    else if (set_begin)
      pending_reg <= select_reg;
    else if ((state_reg == hac_pkg::ST_WAIT) && i_conv_done)
      pending_reg <= pending_left;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_conv_start   <= 1'h0;
      o_conv_channel <= hac_pkg::CH_ANALOG_INPUT_ONE;
    end
    else
    begin
      o_conv_start <= (state_reg == hac_pkg::ST_START) && enable_reg;
      if (state_reg == hac_pkg::ST_START)
        o_conv_channel <= first_set(pending_reg);
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      o_converter_enable <= hac_pkg::ENABLE_RST;
    else
      o_converter_enable <= enable_reg;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_enable_alias: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    wr_pwr |=> (enable_reg == $past(i_reg_wdata[hac_pkg::ENABLE_PWR_BIT]))
               ##1 (o_converter_enable == $past(enable_reg)))
    else $error("enable alias write not applied");

  chk_select_reset: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    $fell(i_reset) |-> (select_reg == 8'h00) && !o_busy)
    else $error("input selects not clear after reset");

  chk_set_order: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    o_conv_start |-> pending_reg[o_conv_channel]
                     && ((pending_reg & ((8'h01 << o_conv_channel) - 8'h01)) == 8'h00))
    else $error("converted input not lowest pending select");

  chk_channel_map: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    $rose(o_busy) && ($past(select_reg) == 8'h80) |=> o_conv_start
                                                      && o_conv_channel == hac_pkg::CH_TEMPERATURE)
    else $error("temperature select not mapped to channel 7");

  chk_cont_no_poll: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    wr_ctrl && i_reg_wdata[hac_pkg::CONT_BIT] && !one_shot_reg |=> !one_shot_reg)
    else $error("one-shot stored in continuous mode");

  chk_poll_clear: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    set_done && !poll_write_one |=> !one_shot_reg)
    else $error("one-shot bit not cleared after set");

  chk_cont_start: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    period_pulse && cont_reg && !gate_start_mode && !blocked && enable_reg
    && (state_reg == hac_pkg::ST_IDLE) && (select_reg != 8'h00) |=> o_busy)
    else $error("continuous period did not start a set");

  chk_gate_block: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (gate_mode_reg == hac_pkg::GATE_BLOCK) && gate_asserted |-> !set_begin)
    else $error("set started while gate blocks");

  chk_gate_only: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    gate_start_mode && set_begin |-> gate_edge)
    else $error("set started by non-gate source in gate mode");

  chk_gate_polarity: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    gate_edge |-> (gate_s2_reg == i_gpio_polarity_config)
                  && ($past(gate_s2_reg) != i_gpio_polarity_config))
    else $error("gate edge against configured polarity");

  chk_gate_start: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    gate_start_mode && gate_edge && enable_reg && (state_reg == hac_pkg::ST_IDLE)
    && (select_reg != 8'h00) |=> o_busy ##1 (o_conv_start || !enable_reg))
    else $error("gate edge did not start a set");

  chk_no_start_off: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    !enable_reg && !$past(enable_reg) |-> !o_conv_start && !one_shot_reg)
    else $error("activity while converter disabled");

  chk_busy_hold: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    o_busy && (state_reg != hac_pkg::ST_IDLE) && !i_conv_done && enable_reg
    |=> pending_reg == $past(pending_reg))
    else $error("set reloaded while busy");

endmodule
`default_nettype wire

// *** hdl/hac_pkg.sv ***
`default_nettype none
package hac_pkg;

  // ****************************************************************
  // Register locations
  // ****************************************************************
  localparam logic [7:0] ADDR_PWR_MGMT5   = 8'h0c;
  localparam logic [7:0] ADDR_TRIG_CTRL   = 8'h90;
  localparam logic [7:0] ADDR_TRIG_CTRL2  = 8'h91;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ENABLE_PWR_BIT  = 7;
  localparam int ENABLE_CTRL_BIT = 15;
  localparam int CONT_BIT        = 14;
  localparam int POLL_BIT        = 13;
  localparam int SEL_LSB         = 0;
  localparam int SEL_MSB         = 7;
  localparam int GATE_MODE_LSB   = 12;
  localparam int GATE_MODE_MSB   = 13;
  localparam int RATE_LSB        = 8;
  localparam int RATE_MSB        = 10;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic       ENABLE_RST    = 1'h0;
  localparam logic       CONT_RST      = 1'h0;
  localparam logic       POLL_RST      = 1'h0;
  localparam logic [7:0] SEL_RST       = 8'h00;
  localparam logic [1:0] GATE_MODE_RST = 2'h0;
  localparam logic [2:0] RATE_RST      = 3'h0;

  // ****************************************************************
  // Gate modes and input channel codes
  // ****************************************************************
  localparam logic [1:0] GATE_IGNORE = 2'h0;
  localparam logic [1:0] GATE_BLOCK  = 2'h1;
  localparam logic [1:0] GATE_RSVD   = 2'h2;
  localparam logic [1:0] GATE_START  = 2'h3;

  localparam logic [2:0] CH_ANALOG_INPUT_ONE   = 3'h0;
  localparam logic [2:0] CH_ANALOG_INPUT_TWO   = 3'h1;
  localparam logic [2:0] CH_ANALOG_INPUT_THREE = 3'h2;
  localparam logic [2:0] CH_ANALOG_INPUT_FOUR  = 3'h3;
  localparam logic [2:0] CH_USB_SUPPLY         = 3'h4;
  localparam logic [2:0] CH_SYSTEM_SUPPLY      = 3'h5;
  localparam logic [2:0] CH_BATTERY_INPUT      = 3'h6;
  localparam logic [2:0] CH_TEMPERATURE        = 3'h7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
  localparam int MIN_RATE_HZ   = 1;
  localparam int MAX_RATE_HZ   = 256;
  localparam int TICK_CYCLES   = CLK_HZ / MAX_RATE_HZ;
  localparam int SLOW_TICKS    = MAX_RATE_HZ / MIN_RATE_HZ;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_START = 3'b010,
    ST_WAIT  = 3'b100
  } hac_state_t;

  // Fast ticks per continuous period; code 0 is the odd one out
  function automatic logic [8:0] ticks_for_rate(input logic [2:0] code);
    if (code == 3'h0)
      ticks_for_rate = 9'(SLOW_TICKS);
    else
      ticks_for_rate = 9'h001 << (3'h7 - code);
  endfunction

endpackage
`default_nettype wire

// *** hdl/hac_rate_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
module hac_rate_divider
#(
  parameter int P_TICK_CYCLES = hac_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  // Control
  input  wire logic       i_run,
  input  wire logic [2:0] i_rate,
  // Period pulse
  output var  logic       o_period
);

  logic [23:0] tick_cnt_reg;
  logic [8:0]  period_cnt_reg;
  logic [2:0]  rate_seen_reg;
  logic        tick_hit;
  logic        period_hit;
  logic        restart;

  assign tick_hit   = tick_cnt_reg == 24'(P_TICK_CYCLES - 1);
  assign period_hit = tick_hit && (period_cnt_reg == hac_pkg::ticks_for_rate(i_rate) - 9'h001);
  // A rate change restarts the period so the count never overshoots
  assign restart    = !i_run || (rate_seen_reg != i_rate);

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      rate_seen_reg <= hac_pkg::RATE_RST;
    else
      rate_seen_reg <= i_rate;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset || restart || tick_hit)
      tick_cnt_reg <= 24'h000000;
    else
      tick_cnt_reg <= tick_cnt_reg + 24'h000001;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset || restart || period_hit)
      period_cnt_reg <= 9'h000;
    else if (tick_hit)
      period_cnt_reg <= period_cnt_reg + 9'h001;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      o_period <= 1'h0;
    else
      o_period <= !restart && period_hit;
  end

  chk_period_spacing: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    o_period |-> $past(period_cnt_reg) == hac_pkg::ticks_for_rate($past(i_rate)) - 9'h001)
    else $error("continuous period does not match rate code");

endmodule
`default_nettype wire

// *** verif/hac_trigger_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************************************
  // Signals and device
  // ****************************************************************
  localparam int TICKS = 4;
  logic        i_mclk      = 1'b0;
  logic        i_reset     = 1'b1;
  logic        i_reg_wr    = 1'b0;
  logic        i_reg_rd    = 1'b0;
  logic [7:0]  i_reg_addr  = 8'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic        i_gate_pin  = 1'b0;
  logic        i_gpio_polarity_config = 1'b1;
  logic        i_conv_done = 1'b0;
  logic [15:0] o_reg_rdata;
  logic        o_converter_enable;
  logic        o_conv_start;
  logic [2:0]  o_conv_channel;
  logic        o_busy;
  logic [1:0]  done_d = 2'h0;
  logic [2:0]  chans[$];
  int          times[$];
  int          cyc = 0;
  int          error_cnt = 0;
  int          checked = 0;

  hac_trigger_control #(.P_TICK_CYCLES(TICKS)) uut
  (
    .i_mclk                 (i_mclk),
    .i_reset                (i_reset),
    .i_reg_wr               (i_reg_wr),
    .i_reg_rd               (i_reg_rd),
    .i_reg_addr             (i_reg_addr),
    .i_reg_wdata            (i_reg_wdata),
    .o_reg_rdata            (o_reg_rdata),
    .i_gate_pin             (i_gate_pin),
    .i_gpio_polarity_config (i_gpio_polarity_config),
    .o_converter_enable     (o_converter_enable),
    .o_conv_start           (o_conv_start),
    .o_conv_channel         (o_conv_channel),
    .i_conv_done            (i_conv_done),
    .o_busy                 (o_busy)
  );

  always #25 i_mclk = ~i_mclk;

  // Converter stand-in: answers every start three cycles later
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    done_d <= {done_d[0], o_conv_start};
    i_conv_done <= done_d[1];
    if (o_conv_start === 1'b1)
    begin
      chans.push_back(o_conv_channel);
      times.push_back(cyc);
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_up;
    error_cnt++;
    $display("unexpected at %0t: timeout seen %h expected %h", $time, 1'b0, 1'b1);
    end_of_test();
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    @(negedge i_mclk);
    d = o_reg_rdata;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 3000 && o_busy !== 1'b0; i++)
      @(negedge i_mclk);
    if (i == 3000)
      give_up();
  endtask

  task automatic wait_starts(input int n, input int bound);
    int i;
    for (i = 0; i < bound && chans.size() < n; i++)
      @(negedge i_mclk);
    if (i == bound)
      give_up();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic reset_and_alias;
    rd_check(hac_pkg::ADDR_PWR_MGMT5, 16'h0000);
    rd_check(hac_pkg::ADDR_TRIG_CTRL, 16'h0000);
    rd_check(hac_pkg::ADDR_TRIG_CTRL2, 16'h0000);
    wr(8'h55, 16'hffff);
    rd_check(8'h55, 16'h0000);
    wr(hac_pkg::ADDR_PWR_MGMT5, 16'hffff);
    rd_check(hac_pkg::ADDR_TRIG_CTRL, 16'h8000);
    check(16'(o_converter_enable), 16'h0001);
    wr(hac_pkg::ADDR_TRIG_CTRL, 16'h0000);
    rd_check(hac_pkg::ADDR_PWR_MGMT5, 16'h0000);
    wr(hac_pkg::ADDR_TRIG_CTRL2, 16'hffff);
    rd_check(hac_pkg::ADDR_TRIG_CTRL2, 16'h3700);
    wr(hac_pkg::ADDR_TRIG_CTRL2, 16'h0000);
  endtask

  task automatic poll_set(input logic [7:0] sel);
    int k;
    int n;
    chans.delete();
    wr(hac_pkg::ADDR_TRIG_CTRL, {8'ha0, sel});
    cyc_wait(3);
    wait_idle();
    cyc_wait(8);
    n = 0;
    for (k = 0; k < 8; k++)
      if (sel[k])
      begin
        if (n < chans.size())
          check(16'(chans[n]), 16'(k));
        n++;
      end
    check(16'(chans.size()), 16'(n));
    rd_check(hac_pkg::ADDR_TRIG_CTRL, {8'h80, sel});
  endtask

  task automatic busy_and_abort;
    // A second one-shot while busy must not queue a further set
    chans.delete();
    wr(hac_pkg::ADDR_TRIG_CTRL, 16'ha003);
    wait_starts(1, 50);
    wr(hac_pkg::ADDR_TRIG_CTRL, 16'ha003);
    wait_idle();
    cyc_wait(30);
    check(16'(chans.size()), 16'h0002);
    chans.delete();
    wr(hac_pkg::ADDR_TRIG_CTRL, 16'ha0ff);
    wait_starts(1, 50);
    wr(hac_pkg::ADDR_TRIG_CTRL, 16'h00ff);
    cyc_wait(3);
    @(negedge i_mclk);
    check(16'(o_busy), 16'h0000);
    check(16'(o_converter_enable), 16'h0000);
    rd_check(hac_pkg::ADDR_TRIG_CTRL, 16'h00ff);
    chans.delete();
    wr(hac_pkg::ADDR_TRIG_CTRL, 16'h20ff);
    cyc_wait(30);
    check(16'(chans.size()), 16'h0000);
    rd_check(hac_pkg::ADDR_TRIG_CTRL, 16'h00ff);
  endtask

  task automatic cont_rate(input logic [2:0] code);
    int per;
    per = TICKS * ((code == 3'h0) ? 256 : (1 << (7 - code)));
    wr(hac_pkg::ADDR_TRIG_CTRL2, {5'h00, code, 8'h00});
    wr(hac_pkg::ADDR_TRIG_CTRL, 16'he001);
    chans.delete();
    times.delete();
    wait_starts(3, 3 * per + 100);
    // A set outlasts the shortest period here, so every other period is lost
    check(16'(times[2] - times[1]), 16'((per < 8) ? 2 * per : per));
    rd_check(hac_pkg::ADDR_TRIG_CTRL, 16'hc001);
    wr(hac_pkg::ADDR_TRIG_CTRL, 16'h8001);
    cyc_wait(10);
    wait_idle();
  endtask

  task automatic gate_block(input logic [1:0] mode, input int exp);
    wr(hac_pkg::ADDR_TRIG_CTRL2, {2'h0, mode, 12'h000});
    @(posedge i_mclk);
    i_gate_pin <= 1'b1;
    cyc_wait(8);
    chans.delete();
    wr(hac_pkg::ADDR_TRIG_CTRL, 16'ha001);
    cyc_wait(30);
    check(16'(chans.size()), 16'(exp));
    @(posedge i_mclk);
    i_gate_pin <= 1'b0;
    cyc_wait(30);
    check(16'(chans.size()), 16'h0001);
  endtask

  task automatic gate_start(input logic pol);
    wr(hac_pkg::ADDR_TRIG_CTRL2, 16'h0000);
    @(posedge i_mclk);
    i_gpio_polarity_config <= pol;
    i_gate_pin <= ~pol;
    cyc_wait(8);
    wr(hac_pkg::ADDR_TRIG_CTRL2, 16'h3600);
    wr(hac_pkg::ADDR_TRIG_CTRL, 16'he001);
    chans.delete();
    cyc_wait(30);
    check(16'(chans.size()), 16'h0000);
    @(posedge i_mclk);
    i_gate_pin <= pol;
    cyc_wait(30);
    check(16'(chans.size()), 16'h0001);
    @(posedge i_mclk);
    i_gate_pin <= ~pol;
    cyc_wait(30);
    check(16'(chans.size()), 16'h0001);
    wr(hac_pkg::ADDR_TRIG_CTRL2, 16'h0000);
    wr(hac_pkg::ADDR_TRIG_CTRL, 16'h8001);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    cyc_wait(16);
    i_reset <= 1'b0;
    reset_and_alias();
    poll_set(8'hff);
    poll_set(8'h05);
    poll_set(8'h50);
    poll_set(8'h80);
    poll_set(8'h00);
    busy_and_abort();
    for (int c = 0; c < 8; c++)
      cont_rate(3'(c));
    gate_block(2'h1, 0);
    gate_block(2'h2, 1);
    gate_start(1'b1);
    gate_start(1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
